/* File: nvmpc_defines.vh */
// offsets, field positions, reset values and address limits of nvmpc
`ifndef NVMPC_DEFINES_VH
`define NVMPC_DEFINES_VH

// =====================================================================
// register byte addresses
`define NVMPC_OFF_CONFIG 12'h000
`define NVMPC_OFF_PROT 12'h004
`define NVMPC_OFF_STATUS 12'h008

// =====================================================================
// field positions
`define NVMPC_CFG_RSVD_BIT 7
`define NVMPC_CFG_PGSEL_BIT 6
`define NVMPC_CFG_KEYWR_BIT 5
`define NVMPC_STAT_VIOL_BIT 5
`define NVMPC_EPS_HI 7
`define NVMPC_EPS_LO 6
`define NVMPC_FPS_HI 5
`define NVMPC_FPS_LO 0

// =====================================================================
// reset values and field codes
`define NVMPC_CONFIG_RST 8'h00
`define NVMPC_PROT_RST 8'hFF
`define NVMPC_EPS_NONE 2'h3
`define NVMPC_FPS_NONE 6'h3F
`define NVMPC_FPS_ALL 6'h18

// =====================================================================
// address limits
`define NVMPC_KEY_LO 16'hFFB0
`define NVMPC_KEY_HI 16'hFFB7
`define NVMPC_EE_TOP 17'h0_17FF
`define NVMPC_EE_B2 17'h0_17F0
`define NVMPC_EE_B1 17'h0_17E0
`define NVMPC_EE_B0 17'h0_17C0
`define NVMPC_EE_NONE 17'h0_1800
`define NVMPC_FL_TOP 17'h1_0000
`define NVMPC_FL_STEP 17'h0_0600

// =====================================================================
// bus responses
`define NVMPC_RESP_OKAY 2'h0
`define NVMPC_RESP_SLVERR 2'h2

`endif

/* File: nvmpc_prot_decode.v */
// decodes the protect fields into lower bounds and checks one address
`default_nettype none
`include "nvmpc_defines.vh"

module nvmpc_prot_decode
(
    input wire [7:0] prot,
    input wire [15:0] addr,
    output reg [16:0] flash_lo,
    output reg [16:0] ee_lo,
    output wire any_prot,
    output wire addr_prot
);

    wire [1:0] eeprom_protect_field;
    wire [5:0] flash_protect_field;
    wire [5:0] steps;
    wire [16:0] addr_x;

    assign eeprom_protect_field = prot[`NVMPC_EPS_HI:`NVMPC_EPS_LO];
    assign flash_protect_field = prot[`NVMPC_FPS_HI:`NVMPC_FPS_LO];
    assign steps = `NVMPC_FPS_NONE - flash_protect_field;
    assign addr_x = {1'b0, addr};

    // =================================================================
    // flash bound, moving down from the top 0x600 bytes per step
    always @*
    begin
        if (flash_protect_field <= `NVMPC_FPS_ALL)
        begin
            flash_lo = 17'h0_0000;
        end
        else
        begin
            flash_lo = `NVMPC_FL_TOP - ({11'h000, steps} * `NVMPC_FL_STEP);
        end
    end

    // =================================================================
    // eeprom bound
    always @*
    begin
        if (eeprom_protect_field == 2'h2)
        begin
            ee_lo = `NVMPC_EE_B2;
        end
        else if (eeprom_protect_field == 2'h1)
        begin
            ee_lo = `NVMPC_EE_B1;
        end
        else if (eeprom_protect_field == 2'h0)
        begin
            ee_lo = `NVMPC_EE_B0;
        end
        else
        begin
            ee_lo = `NVMPC_EE_NONE;
        end
    end

    // =================================================================
    // address check against both bounds
    assign any_prot = (eeprom_protect_field != `NVMPC_EPS_NONE) || (flash_protect_field != `NVMPC_FPS_NONE);
    assign addr_prot = (addr_x >= flash_lo) ||
        ((addr_x >= ee_lo) && (addr_x <= `NVMPC_EE_TOP));

endmodule

`default_nettype wire

/* File: nvmpc_top.v */
// nvm protection and configuration registers with an axi4-lite slave
`default_nettype none
`include "nvmpc_defines.vh"

module nvmpc_top
(
    input wire clock,
    input wire rst_n,
    input wire [11:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [11:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire [7:0] stored_protection_byte,
    input wire dbg_prot_wr,
    input wire [7:0] dbg_prot_data,
    input wire cpu_wr_valid,
    input wire [15:0] cpu_wr_addr,
    input wire pe_valid,
    input wire [15:0] pe_addr,
    input wire pe_mass,
    output reg pe_launch,
    output reg pe_refused,
    output reg key_cmp_wr,
    output reg pe_start_wr,
    output reg eeprom_page_select,
    output reg [1:0] eeprom_page_en,
    output reg [7:0] prot_value
);

    // =================================================================
    // state
    reg [7:0] config_q;
    reg [7:0] config_d;
    reg [7:0] prot_q;
    reg [7:0] prot_d;
    reg viol_q;
    reg viol_d;
    reg load_pend_q;
    reg aw_have_q;
    reg [11:0] aw_addr_q;
    reg w_have_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;

    wire do_write;
    wire [11:0] wr_addr;
    wire [31:0] wr_data;
    wire [3:0] wr_strb;
    wire wr_cfg;
    wire wr_prot;
    wire wr_stat;
    wire wr_hit;
    wire [7:0] new_prot;
    wire [16:0] cur_flash_lo;
    wire [16:0] cur_ee_lo;
    wire [16:0] new_flash_lo;
    wire [16:0] new_ee_lo;
    wire cur_any;
    wire cur_addr_prot;
    wire grow_ok;
    wire key_hit;
    wire pe_bad;
    reg [31:0] rd_word;
    reg rd_err;

    // =================================================================
    // write channel capture, either order
    assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
    assign s_axi_wready = !w_have_q && !s_axi_bvalid;

    assign wr_addr = aw_have_q ? aw_addr_q : s_axi_awaddr;
    assign wr_data = w_have_q ? w_data_q : s_axi_wdata;
    assign wr_strb = w_have_q ? w_strb_q : s_axi_wstrb;
    assign do_write = (aw_have_q || (s_axi_awvalid && s_axi_awready)) &&
        (w_have_q || (s_axi_wvalid && s_axi_wready));

    assign wr_cfg = do_write && (wr_addr == `NVMPC_OFF_CONFIG) && wr_strb[0];
    assign wr_prot = do_write && (wr_addr == `NVMPC_OFF_PROT) && wr_strb[0];
    assign wr_stat = do_write && (wr_addr == `NVMPC_OFF_STATUS) &&
        wr_strb[0];
    assign wr_hit = (wr_addr == `NVMPC_OFF_CONFIG) ||
        (wr_addr == `NVMPC_OFF_PROT) || (wr_addr == `NVMPC_OFF_STATUS);
    assign new_prot = wr_data[7:0];

    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            aw_have_q <= 1'b0;
            aw_addr_q <= 12'h000;
            w_have_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `NVMPC_RESP_OKAY;
        end
        else
        begin
            if (do_write)
            begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `NVMPC_RESP_OKAY :
                    `NVMPC_RESP_SLVERR;
            end
            else
            begin
                if (s_axi_awvalid && s_axi_awready)
                begin
                    aw_have_q <= 1'b1;
                    aw_addr_q <= s_axi_awaddr;
                end
                if (s_axi_wvalid && s_axi_wready)
                begin
                    w_have_q <= 1'b1;
                    w_data_q <= s_axi_wdata;
                    w_strb_q <= s_axi_wstrb;
                end
                if (s_axi_bvalid && s_axi_bready)
                begin
                    s_axi_bvalid <= 1'b0;
                end
            end
        end
    end

    // =================================================================
    // protection bounds, current and proposed
    nvmpc_prot_decode u_cur
    (
        .prot(prot_q),
        .addr(pe_addr),
        .flash_lo(cur_flash_lo),
        .ee_lo(cur_ee_lo),
        .any_prot(cur_any),
        .addr_prot(cur_addr_prot)
    );

    nvmpc_prot_decode u_new
    (
        .prot(new_prot),
        .addr(16'h0000),
        .flash_lo(new_flash_lo),
        .ee_lo(new_ee_lo),
        .any_prot(),
        .addr_prot()
    );

    // a bus write may not raise a lower bound, so it never shrinks the region
    assign grow_ok = (new_flash_lo <= cur_flash_lo) &&
        (new_ee_lo <= cur_ee_lo);

    // =================================================================
    // configuration register
    always @*
    begin
        config_d = config_q;
        if (wr_cfg)
        begin
            config_d = {wr_data[`NVMPC_CFG_RSVD_BIT],
                wr_data[`NVMPC_CFG_PGSEL_BIT],
                wr_data[`NVMPC_CFG_KEYWR_BIT], 5'h00};
        end
    end

    // =================================================================
    // protection register
    always @*
    begin
        prot_d = prot_q;
        if (load_pend_q)
        begin
            prot_d = stored_protection_byte;
        end
        else if (dbg_prot_wr)
        begin
            prot_d = dbg_prot_data;
        end
        else if (wr_prot && grow_ok)
        begin
            prot_d = new_prot;
        end
        else
        begin
            prot_d = prot_q;
        end
    end

    // =================================================================
    // violation flag, a new event wins over the clear
    assign pe_bad = pe_valid && (cur_addr_prot || (pe_mass && cur_any));

    always @*
    begin
        viol_d = viol_q;
        if (wr_stat && wr_data[`NVMPC_STAT_VIOL_BIT])
        begin
            viol_d = 1'b0;
        end
        if (pe_bad && !load_pend_q)
        begin
            viol_d = 1'b1;
        end
    end

    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            config_q <= `NVMPC_CONFIG_RST;
            prot_q <= `NVMPC_PROT_RST;
            viol_q <= 1'b0;
            load_pend_q <= 1'b1;
        end
        else
        begin
            config_q <= config_d;
            prot_q <= prot_d;
            viol_q <= viol_d;
            load_pend_q <= 1'b0;
        end
    end

    // =================================================================
    // command launch check
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            pe_launch <= 1'b0;
            pe_refused <= 1'b0;
        end
        else
        begin
            pe_launch <= pe_valid && !pe_bad && !load_pend_q;
            pe_refused <= pe_valid && (pe_bad || load_pend_q);
        end
    end

    // =================================================================
    // key window routing
    assign key_hit = cpu_wr_valid && (cpu_wr_addr >= `NVMPC_KEY_LO) &&
        (cpu_wr_addr <= `NVMPC_KEY_HI);

    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            key_cmp_wr <= 1'b0;
            pe_start_wr <= 1'b0;
        end
        else
        begin
            key_cmp_wr <= key_hit && config_q[`NVMPC_CFG_KEYWR_BIT];
            pe_start_wr <= key_hit &&
                !config_q[`NVMPC_CFG_KEYWR_BIT];
        end
    end

    // =================================================================
    // page mapping and protection value outputs
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            eeprom_page_select <= 1'b0;
            eeprom_page_en <= 2'h1;
            prot_value <= `NVMPC_PROT_RST;
        end
        else
        begin
            eeprom_page_select <= config_d[`NVMPC_CFG_PGSEL_BIT];
            eeprom_page_en <= config_d[`NVMPC_CFG_PGSEL_BIT] ?
                2'h2 : 2'h1;
            prot_value <= prot_d;
        end
    end

    // =================================================================
    // read channel
    assign s_axi_arready = !s_axi_rvalid;

    always @*
    begin
        rd_word = 32'h0000_0000;
        rd_err = 1'b0;
        if (s_axi_araddr == `NVMPC_OFF_CONFIG)
        begin
            rd_word = {24'h00_0000, config_q};
        end
        else if (s_axi_araddr == `NVMPC_OFF_PROT)
        begin
            rd_word = {24'h00_0000, prot_q};
        end
        else if (s_axi_araddr == `NVMPC_OFF_STATUS)
        begin
            rd_word = {26'h000_0000, viol_q, 5'h00};
        end
        else
        begin
            rd_err = 1'b1;
        end
    end

    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `NVMPC_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_err ? `NVMPC_RESP_SLVERR : `NVMPC_RESP_OKAY;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

`default_nettype wire

/* File: nvmpc_monitor.sv */
// port-level checker for nvmpc_top
`default_nettype none
module nvmpc_monitor
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic s_axi_bvalid,
    input wire logic [7:0] stored_protection_byte,
    input wire logic dbg_prot_wr,
    input wire logic cpu_wr_valid,
    input wire logic [15:0] cpu_wr_addr,
    input wire logic pe_valid,
    input wire logic [15:0] pe_addr,
    input wire logic pe_mass,
    input wire logic pe_launch,
    input wire logic pe_refused,
    input wire logic key_cmp_wr,
    input wire logic pe_start_wr,
    input wire logic eeprom_page_select,
    input wire logic [1:0] eeprom_page_en,
    input wire logic [7:0] prot_value
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    // ====================
    // protection decode
    function automatic logic bad(logic [7:0] p, logic [15:0] a, logic m);
        logic [16:0] fl;
        logic [16:0] el;
        begin
            fl = 17'h1_0000 - (17'h0_003F - p[5:0]) * 17'h0_0600;
            if (p[5:0] <= 6'h18)
                fl = 17'h0_0000;
            el = p[7:6] == 2'h3 ? 17'h0_1800 : p[7:6] == 2'h2 ? 17'h0_17F0
                : p[7:6] == 2'h1 ? 17'h0_17E0 : 17'h0_17C0;
            bad = ({1'b0, a} >= fl) || (a <= 16'h17FF && {1'b0, a} >= el)
                || (m && p != 8'hFF);
        end
    endfunction

    // ====================
    // sequences and assertions
    sequence s_key_wr;
        cpu_wr_valid && cpu_wr_addr >= 16'hFFB0 && cpu_wr_addr <= 16'hFFB7;
    endsequence
    sequence s_pe_bad;
        pe_valid && bad(prot_value, pe_addr, pe_mass);
    endsequence
    sequence s_bus_chg;
        $changed(prot_value) && !$past(dbg_prot_wr) && $past(rst_n, 2);
    endsequence

    a_page_map: assert property (eeprom_page_en ==
        (eeprom_page_select ? 2'h2 : 2'h1)) else $error("page map wrong");
    a_key_take: assert property (s_key_wr |=>
        key_cmp_wr != pe_start_wr) else $error("key write lost");
    a_key_quiet: assert property (!(cpu_wr_valid && cpu_wr_addr >=
        16'hFFB0 && cpu_wr_addr <= 16'hFFB7) |=> !key_cmp_wr && !pe_start_wr)
        else $error("key pulse without cause");
    a_pe_answer: assert property (pe_valid |=>
        pe_launch != pe_refused) else $error("attempt not answered");
    a_pe_quiet: assert property (!pe_valid |=>
        !pe_launch && !pe_refused) else $error("pulse without attempt");
    a_pe_block: assert property (s_pe_bad |=>
        pe_refused) else $error("protected attempt launched");
    a_pe_allow: assert property (pe_valid && $past(rst_n) &&
        !bad(prot_value, pe_addr, pe_mass) |=> pe_launch)
        else $error("free attempt refused");
    a_prot_load: assert property ($rose(rst_n) && !dbg_prot_wr |=>
        prot_value == $past(stored_protection_byte)) else $error("no load");
    a_prot_cause: assert property ($changed(prot_value) |->
        $rose(s_axi_bvalid) || $past(dbg_prot_wr) || !$past(rst_n)
        || !$past(rst_n, 2)) else $error("protection changed alone");
    a_no_shrink: assert property (s_bus_chg |->
        prot_value[7:6] <= $past(prot_value[7:6]) && (prot_value[5:0] <=
        6'h18 || prot_value[5:0] <= $past(prot_value[5:0])))
        else $error("protection shrank");
endmodule

bind nvmpc_top nvmpc_monitor nvmpc_monitor_inst
(
    .clock, .rst_n, .s_axi_bvalid, .stored_protection_byte, .dbg_prot_wr,
    .cpu_wr_valid, .cpu_wr_addr, .pe_valid, .pe_addr, .pe_mass, .pe_launch,
    .pe_refused, .key_cmp_wr, .pe_start_wr, .eeprom_page_select,
    .eeprom_page_en, .prot_value
);
`default_nettype wire

/* File: tb_top.sv */
// self-checking testbench for nvmpc_top
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, dbg_prot_wr;
    logic cpu_wr_valid, pe_valid, pe_mass, pe_launch, pe_refused;
    logic key_cmp_wr, pe_start_wr, eeprom_page_select;
    logic [1:0] s_axi_bresp, s_axi_rresp, eeprom_page_en;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [7:0] stored_protection_byte, dbg_prot_data, prot_value;
    logic [15:0] cpu_wr_addr, pe_addr;
    logic [16:0] bnd;
    int err_count, compares, cycles, f;

    nvmpc_top nvmpc_top_inst
    (
        .clock, .rst_n, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .stored_protection_byte, .dbg_prot_wr, .dbg_prot_data, .cpu_wr_valid,
        .cpu_wr_addr, .pe_valid, .pe_addr, .pe_mass, .pe_launch, .pe_refused,
        .key_cmp_wr, .pe_start_wr, .eeprom_page_select, .eeprom_page_en,
        .prot_value
    );

    // ====================
    // clock, timeout, report
    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            err_count++;
            complete_run();
        end
    end
    task complete_run;
        begin
            if (err_count == 0 && compares > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        begin
            compares++;
            if (g !== e)
            begin
                err_count++;
                $display("mismatch %s expected %h seen %h", n, e, g);
            end
        end
    endtask

    // ====================
    // access tasks
    task axi_wr(input logic [11:0] a, input logic [31:0] d,
        input logic [1:0] r);
        logic aw, w, b;
        begin
            b = 1'b0;
            @(posedge clock);
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            while (!b)
            begin
                @(negedge clock);
                aw = s_axi_awvalid && s_axi_awready;
                w = s_axi_wvalid && s_axi_wready;
                b = s_axi_bvalid;
                if (b)
                    chk("bresp", r, s_axi_bresp);
                @(posedge clock);
                if (aw)
                    s_axi_awvalid <= 1'b0;
                if (w)
                    s_axi_wvalid <= 1'b0;
            end
            s_axi_bready <= 1'b0;
        end
    endtask
    task axi_rd(input logic [11:0] a, input logic [31:0] d,
        input logic [1:0] r);
        logic ar, v;
        begin
            v = 1'b0;
            @(posedge clock);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            while (!v)
            begin
                @(negedge clock);
                ar = s_axi_arvalid && s_axi_arready;
                v = s_axi_rvalid;
                if (v)
                begin
                    chk("rdata", d, s_axi_rdata);
                    chk("rresp", r, s_axi_rresp);
                end
                @(posedge clock);
                if (ar)
                    s_axi_arvalid <= 1'b0;
            end
            s_axi_rready <= 1'b0;
        end
    endtask
    task pe(input logic [15:0] a, input logic m, input logic ok);
        begin
            @(posedge clock);
            pe_valid <= 1'b1;
            pe_addr <= a;
            pe_mass <= m;
            @(posedge clock);
            pe_valid <= 1'b0;
            @(negedge clock);
            chk("pe_launch", ok, pe_launch);
            chk("pe_refused", !ok, pe_refused);
        end
    endtask
    task kw(input logic [15:0] a, input logic k, input logic s);
        begin
            @(posedge clock);
            cpu_wr_valid <= 1'b1;
            cpu_wr_addr <= a;
            @(posedge clock);
            cpu_wr_valid <= 1'b0;
            @(negedge clock);
            chk("key_cmp_wr", k, key_cmp_wr);
            chk("pe_start_wr", s, pe_start_wr);
        end
    endtask
    task dbg(input logic [7:0] d);
        begin
            @(posedge clock);
            dbg_prot_wr <= 1'b1;
            dbg_prot_data <= d;
            @(posedge clock);
            dbg_prot_wr <= 1'b0;
            @(negedge clock);
            chk("prot_value", d, prot_value);
        end
    endtask

    // ====================
    // main sequence
    initial
    begin
        {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, dbg_prot_wr, cpu_wr_valid} = 4'h0;
        {pe_valid, pe_mass, s_axi_awaddr, s_axi_araddr} = 26'h000_0000;
        {s_axi_wdata, dbg_prot_data, cpu_wr_addr, pe_addr} = 72'h0;
        {err_count, compares, cycles} = {32'h0, 32'h0, 32'h0};
        stored_protection_byte = 8'hBE;
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        @(negedge clock);
        chk("prot_load", 8'hBE, prot_value);
        axi_rd(12'h004, 32'h0000_00BE, 2'h0);
        axi_wr(12'h000, 32'h0000_00C0, 2'h0);
        @(negedge clock);
        chk("page_en", 2'h2, eeprom_page_en);
        chk("page_sel", 1'b1, eeprom_page_select);
        axi_rd(12'h000, 32'h0000_00C0, 2'h0);
        axi_wr(12'h000, 32'h0000_0080, 2'h0);
        @(negedge clock);
        chk("page_en", 2'h1, eeprom_page_en);
        chk("page_sel", 1'b0, eeprom_page_select);
        kw(16'hFFB0, 1'b0, 1'b1);
        kw(16'hFFB7, 1'b0, 1'b1);
        kw(16'hFFB8, 1'b0, 1'b0);
        axi_wr(12'h000, 32'h0000_00A0, 2'h0);
        kw(16'hFFB3, 1'b1, 1'b0);
        kw(16'hFFAF, 1'b0, 1'b0);
        pe(16'hFA00, 1'b0, 1'b0);
        axi_rd(12'h008, 32'h0000_0020, 2'h0);
        axi_wr(12'h008, 32'h0000_0020, 2'h0);
        axi_rd(12'h008, 32'h0000_0000, 2'h0);
        pe(16'hF9FF, 1'b0, 1'b1);
        pe(16'h17F0, 1'b0, 1'b0);
        pe(16'h17EF, 1'b0, 1'b1);
        pe(16'h0100, 1'b1, 1'b0);
        axi_wr(12'h004, 32'h0000_00FF, 2'h0);
        axi_rd(12'h004, 32'h0000_00BE, 2'h0);
        axi_wr(12'h004, 32'h0000_007D, 2'h0);
        axi_rd(12'h004, 32'h0000_007D, 2'h0);
        pe(16'h17E0, 1'b0, 1'b0);
        axi_wr(12'h004, 32'h0000_0018, 2'h0);
        pe(16'h0000, 1'b0, 1'b0);
        axi_wr(12'h004, 32'h0000_0000, 2'h0);
        axi_rd(12'h004, 32'h0000_0000, 2'h0);
        axi_wr(12'h004, 32'h0000_0040, 2'h0);
        axi_rd(12'h004, 32'h0000_0000, 2'h0);
        axi_wr(12'h00C, 32'h0000_0001, 2'h2);
        axi_rd(12'h00C, 32'h0000_0000, 2'h2);
        dbg(8'hFF);
        pe(16'h0100, 1'b1, 1'b1);
        for (f = 0; f < 3; f++)
        begin
            axi_wr(12'h004, {24'h0, 2'(2 - f), 6'h3F}, 2'h0);
            bnd = 17'h0_1800 - (17'h0_0010 << f);
            pe(bnd[15:0], 1'b0, 1'b0);
            pe(bnd[15:0] - 16'h0001, 1'b0, 1'b1);
        end
        dbg(8'hFF);
        for (f = 62; f >= 25; f--)
        begin
            axi_wr(12'h004, {24'h0, 2'h3, 6'(f)}, 2'h0);
            bnd = 17'h1_0000 - 17'(63 - f) * 17'h0_0600;
            pe(bnd[15:0], 1'b0, 1'b0);
            pe(bnd[15:0] - 16'h0001, 1'b0, 1'b1);
        end
        // ====================
        // reprogrammed stored byte, then a second reset
        @(posedge clock);
        stored_protection_byte <= 8'hB9;
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        @(negedge clock);
        chk("prot_rst", 8'hFF, prot_value);
        @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        @(negedge clock);
        chk("prot_load", 8'hB9, prot_value);
        axi_rd(12'h008, 32'h0000_0000, 2'h0);
        pe(16'hDC00, 1'b0, 1'b0);
        pe(16'hDBFF, 1'b0, 1'b1);
        complete_run();
    end
endmodule
`default_nettype wire
